// ===== inc/flash_front_pkg.sv
`default_nettype none
package flash_front_pkg;

	// Pin sampling
	localparam int PIN_W = 6;
	localparam int PIN_CS = 5;
	localparam int PIN_SCK = 4;
	localparam logic [5:0] PIN_IDLE = 6'h20;

	// Array geometry and protection granules
	localparam logic [23:0] MEM_TOP = 24'h3F_FFFF;
	localparam logic [23:0] SIZE_64K = 24'h01_0000;
	localparam logic [23:0] SIZE_4K = 24'h00_1000;
	localparam logic [23:0] ADDR_ONE = 24'h00_0001;
	localparam logic [23:0] MASK_PAGE = 24'h00_00FF;
	localparam logic [23:0] MASK_4K = 24'h00_0FFF;
	localparam logic [23:0] MASK_32K = 24'h00_7FFF;
	localparam logic [23:0] MASK_64K = 24'h00_FFFF;
	localparam logic [23:0] MASK_CHIP = 24'hFF_FFFF;

	// Opcodes
	localparam logic [7:0] OP_WR_STATUS = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_QUAD_PROG = 8'h32;
	localparam logic [7:0] OP_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_ERASE_64K = 8'hD8;
	localparam logic [7:0] OP_CHIP_A = 8'hC7;
	localparam logic [7:0] OP_CHIP_B = 8'h60;
	localparam logic [7:0] OP_OTP_PROG = 8'h42;
	localparam logic [7:0] OP_OTP_ERASE = 8'h44;
	localparam logic [7:0] OP_RD_STATUS = 8'h05;
	localparam logic [7:0] OP_ID_RELEASE = 8'hAB;
	localparam logic [7:0] OP_ID_PAIR = 8'h90;
	localparam logic [7:0] OP_ID_DUAL = 8'h92;
	localparam logic [7:0] OP_ID_QUAD = 8'h94;
	localparam logic [7:0] OP_ID_WORD = 8'h9F;

	// Least byte counts per frame kind, counter limits
	localparam logic [2:0] LEN_CMD = 3'h1;
	localparam logic [2:0] LEN_WSR = 3'h2;
	localparam logic [2:0] LEN_ADDR = 3'h4;
	localparam logic [2:0] LEN_PROG = 3'h5;
	localparam logic [2:0] BYTE_MAX = 3'h7;
	localparam logic [2:0] ID_AFTER = 3'h3;
	localparam logic [2:0] STEP_ONE = 3'h1;
	localparam logic [2:0] STEP_QUAD = 3'h4;

	typedef struct packed {
		logic [7:0] code;
		logic [23:0] addr;
	} op_req_type;

	typedef struct packed {
		logic any;
		logic [23:0] lo;
		logic [23:0] hi;
	} prot_range_type;

	typedef enum logic [1:0] {S_IDLE, S_COLLECT, S_BLOCKED} frame_state_type;

endpackage
`default_nettype wire

// ===== rtl/flash_cmd_front.sv
`default_nettype none
module flash_cmd_front import flash_front_pkg::*; #(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
	parameter logic [7:0] DEVICE_CODE_BYTE = 8'h3C, // Arbitrary value
	parameter logic [15:0] DEVICE_CODE_WORD = 16'hC3A5 // Arbitrary value
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CS_N,
	input wire logic SPI_CLK,
	input wire logic [3:0] IO_I,
	output logic [3:0] IO_O,
	output logic [3:0] IO_OE,
	input wire logic QUAD_INSTRUCTION_MODE,
	input wire logic SECTOR_GRANULARITY_SELECT,
	input wire logic TOP_BOTTOM_SELECT,
	input wire logic BLOCK_PROTECT_MSB,
	input wire logic BLOCK_PROTECT_MID,
	input wire logic BLOCK_PROTECT_LSB,
	input wire logic COMPLEMENT_PROTECT,
	input wire logic [7:1] STATUS_BITS,
	input wire logic OP_DONE,
	output logic BUSY,
	output logic OP_START,
	output var op_req_type OP_REQ,
	output logic IGNORED
);
	logic [PIN_W-1:0] pins;
	logic [PIN_W-1:0] lvl;
	logic cs_lvl, sck_lvl, prev_cs_q, prev_sck_q;
	logic [3:0] io_lvl;
	logic cs_fall, cs_rise, sck_rise, sck_fall, byte_done, quad;
	logic [2:0] bit_step, bit_nxt, bit_q, byte_q, need;
	logic [7:0] sh_q, shift_nxt, opcode_q, status_byte;
	logic [23:0] addr_q, mask, tgt_lo, tgt_hi;
	logic is_prog, is_erase, is_chip, is_wsr, is_otp, array_op, is_write;
	logic hit, ok, accept, reject, first_byte, rd_status, id_word, id_late;
	logic load_hit, pend_q, tx_en_q, busy_q, op_start_q, ignored_q;
	logic [23:0] load_val, pend_val_q, tx_q;
	logic [3:0] io_o_q, io_oe_q;
	op_req_type op_req_q;
	prot_range_type prot;
	frame_state_type state_q;

	// Three-stage pin sampling; a level counts once stages two and three agree
	assign pins = {CS_N, SPI_CLK, IO_I};
	for (genvar g = 0; g < PIN_W; g++)
	begin : g_sync
		logic s1_q, s2_q, s3_q, lvl_q;
		always_ff @(posedge CLK or negedge RST_N)
		begin
			if (!RST_N)
			begin
				s1_q <= PIN_IDLE[g];
				s2_q <= PIN_IDLE[g];
				s3_q <= PIN_IDLE[g];
				lvl_q <= PIN_IDLE[g];
			end
			else
			begin
				s1_q <= pins[g];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q)
					lvl_q <= s3_q;
			end
		end
		assign lvl[g] = lvl_q;
	end

	// Edge detection on filtered levels
	assign cs_lvl = lvl[PIN_CS];
	assign sck_lvl = lvl[PIN_SCK];
	assign io_lvl = lvl[3:0];
	assign cs_fall = prev_cs_q && !cs_lvl;
	assign cs_rise = !prev_cs_q && cs_lvl;
	assign sck_rise = sck_lvl && !prev_sck_q && !cs_lvl;
	assign sck_fall = !sck_lvl && prev_sck_q && !cs_lvl;

	// Bit assembly, MSB first, one or four lines
	assign quad = QUAD_INSTRUCTION_MODE;
	assign bit_step = quad ? STEP_QUAD : STEP_ONE;
	assign bit_nxt = bit_q + bit_step;
	assign shift_nxt = quad ? {sh_q[3:0], io_lvl} : {sh_q[6:0], io_lvl[0]};
	assign byte_done = sck_rise && (bit_nxt == 3'h0) && (state_q != S_IDLE);
	assign first_byte = byte_q == 3'h0;

	// Instruction class of the captured opcode
	assign is_prog = (opcode_q == OP_PAGE_PROG) || (opcode_q == OP_QUAD_PROG);
	assign is_erase = (opcode_q == OP_ERASE_4K) || (opcode_q == OP_ERASE_32K) ||
		(opcode_q == OP_ERASE_64K);
	assign is_chip = (opcode_q == OP_CHIP_A) || (opcode_q == OP_CHIP_B);
	assign is_wsr = opcode_q == OP_WR_STATUS;
	assign is_otp = (opcode_q == OP_OTP_PROG) || (opcode_q == OP_OTP_ERASE);
	assign array_op = is_prog || is_erase || is_chip;
	assign is_write = array_op || is_wsr || is_otp;
	assign need = (is_prog || opcode_q == OP_OTP_PROG) ? LEN_PROG :
		(is_erase || opcode_q == OP_OTP_ERASE) ? LEN_ADDR :
		is_wsr ? LEN_WSR : LEN_CMD;

	// Target range of erase block or program page
	assign mask = is_prog ? MASK_PAGE :
		(opcode_q == OP_ERASE_4K) ? MASK_4K :
		(opcode_q == OP_ERASE_32K) ? MASK_32K :
		(opcode_q == OP_ERASE_64K) ? MASK_64K : MASK_CHIP;
	assign tgt_lo = addr_q & ~mask;
	assign tgt_hi = addr_q | mask;
	assign hit = prot.any && (tgt_lo <= prot.hi) && (tgt_hi >= prot.lo);

	// Completion decision at chip select rising
	assign ok = (bit_q == 3'h0) && (byte_q >= need) && !(array_op && hit);
	assign accept = cs_rise && (state_q == S_COLLECT) && is_write && ok;
	assign reject = cs_rise && ((state_q == S_BLOCKED) ||
		((state_q == S_COLLECT) && is_write && !ok));

	// Readback payload selection
	assign status_byte = {STATUS_BITS, busy_q};
	assign rd_status = first_byte && (shift_nxt == OP_RD_STATUS);
	assign id_word = first_byte && (shift_nxt == OP_ID_WORD) && (state_q == S_COLLECT);
	assign id_late = (byte_q == ID_AFTER) && (state_q == S_COLLECT);
	assign load_hit = byte_done && (rd_status || id_word || (id_late &&
		(opcode_q == OP_ID_RELEASE || opcode_q == OP_ID_PAIR ||
		opcode_q == OP_ID_DUAL || opcode_q == OP_ID_QUAD)));
	assign load_val = rd_status ? {3{status_byte}} :
		id_word ? {MAKER_CODE, DEVICE_CODE_WORD} :
		(opcode_q == OP_ID_RELEASE) ? {3{DEVICE_CODE_BYTE}} :
		{MAKER_CODE, DEVICE_CODE_BYTE, MAKER_CODE};

	prot_range_decode u_decode (
		.sector_granularity_select(SECTOR_GRANULARITY_SELECT),
		.top_bottom_select(TOP_BOTTOM_SELECT),
		.block_protect({BLOCK_PROTECT_MSB, BLOCK_PROTECT_MID, BLOCK_PROTECT_LSB}),
		.complement_protect(COMPLEMENT_PROTECT),
		.prot(prot)
	);

	// Frame state and byte collection
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_q <= S_IDLE;
			bit_q <= '0;
			byte_q <= '0;
			sh_q <= '0;
			opcode_q <= '0;
			addr_q <= '0;
		end
		else if (cs_fall)
		begin
			state_q <= busy_q ? S_BLOCKED : S_COLLECT;
			bit_q <= '0;
			byte_q <= '0;
		end
		else if (cs_rise)
		begin
			state_q <= S_IDLE;
			bit_q <= '0;
			byte_q <= '0;
		end
		else if (sck_rise && state_q != S_IDLE)
		begin
			bit_q <= bit_nxt;
			sh_q <= shift_nxt;
			if (byte_done)
			begin
				byte_q <= (byte_q == BYTE_MAX) ? byte_q : byte_q + 3'h1;
				if (first_byte)
					opcode_q <= shift_nxt;
				if (!first_byte && byte_q <= ID_AFTER)
					addr_q <= {addr_q[15:0], shift_nxt};
				if (state_q == S_BLOCKED && rd_status)
					state_q <= S_COLLECT;
			end
		end
	end

	// Output shifter, advanced on falling serial clock
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pend_q <= 1'h0;
			pend_val_q <= '0;
			tx_q <= '0;
			tx_en_q <= 1'h0;
		end
		else if (cs_rise || cs_fall)
		begin
			pend_q <= 1'h0;
			tx_en_q <= 1'h0;
		end
		else if (load_hit)
		begin
			pend_q <= 1'h1;
			pend_val_q <= load_val;
		end
		else if (sck_fall && pend_q)
		begin
			pend_q <= 1'h0;
			tx_q <= pend_val_q;
			tx_en_q <= 1'h1;
		end
		else if (sck_fall && tx_en_q)
			tx_q <= quad ? {tx_q[19:0], 4'h0} : {tx_q[22:0], 1'h0};
	end

	// Busy flag and operation hand-off
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			busy_q <= 1'h0;
			op_start_q <= 1'h0;
			ignored_q <= 1'h0;
			op_req_q <= '0;
		end
		else
		begin
			op_start_q <= accept;
			ignored_q <= reject;
			if (accept)
				op_req_q <= '{code: opcode_q, addr: addr_q};
			if (accept)
				busy_q <= 1'h1;
			else if (OP_DONE)
				busy_q <= 1'h0;
		end
	end

	// Pin drivers and edge history
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			prev_cs_q <= 1'h1;
			prev_sck_q <= 1'h0;
			io_o_q <= '0;
			io_oe_q <= '0;
		end
		else
		begin
			prev_cs_q <= cs_lvl;
			prev_sck_q <= sck_lvl;
			io_o_q <= quad ? tx_q[23:20] : {2'h0, tx_q[23], 1'h0};
			io_oe_q <= (tx_en_q && !cs_lvl) ? (quad ? 4'hF : 4'h2) : 4'h0;
		end
	end

	assign IO_O = io_o_q;
	assign IO_OE = io_oe_q;
	assign BUSY = busy_q;
	assign OP_START = op_start_q;
	assign OP_REQ = op_req_q;
	assign IGNORED = ignored_q;

	// Checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_cs_up;
		cs_rise;
	endsequence
	sequence s_drive_off;
		!tx_en_q ##1 (io_oe_q == 4'h0);
	endsequence
	sequence s_start_pulse;
		op_start_q && busy_q ##1 !op_start_q;
	endsequence

	AST_ABORT: assert property (s_cs_up |=> s_drive_off)
		else $error("Output still driven after frame end");
	AST_CS_CLEAR: assert property (s_cs_up |=> (bit_q == 3'h0) && (state_q == S_IDLE))
		else $error("Bit counter not cleared at frame end");
	AST_PARTIAL: assert property (cs_rise && bit_q != 3'h0 |=> !op_start_q)
		else $error("Partial byte frame was started");
	AST_PROTECTED: assert property (cs_rise && array_op && hit |=> !op_start_q)
		else $error("Protected target was started");
	AST_BUSY_IGNORE: assert property (cs_rise && state_q == S_BLOCKED
		|=> !op_start_q && ignored_q)
		else $error("Instruction taken while busy");
	AST_BUSY_SET: assert property ($rose(busy_q) |-> s_start_pulse)
		else $error("Busy rose without a start");
	AST_BUSY_HOLD: assert property (busy_q && !OP_DONE |=> busy_q)
		else $error("Busy dropped before completion");
	AST_BUSY_CLEAR: assert property (busy_q && OP_DONE && !accept |=> !busy_q)
		else $error("Busy not cleared at completion");
	AST_OPCODE: assert property (byte_done && first_byte && state_q == S_COLLECT
		|=> opcode_q == $past(shift_nxt))
		else $error("Opcode not taken from first byte");
	AST_CMP_NONE: assert property (COMPLEMENT_PROTECT && BLOCK_PROTECT_MSB &&
		BLOCK_PROTECT_MID && BLOCK_PROTECT_LSB |-> !prot.any)
		else $error("Complement with code 111 still protects");
	AST_CMP_SECTOR: assert property (COMPLEMENT_PROTECT && SECTOR_GRANULARITY_SELECT &&
		TOP_BOTTOM_SELECT && !BLOCK_PROTECT_MSB && !BLOCK_PROTECT_MID &&
		BLOCK_PROTECT_LSB |-> prot.any && prot.lo == SIZE_4K && prot.hi == MEM_TOP)
		else $error("Bottom 4KB complement range wrong");

endmodule // flash_cmd_front
`default_nettype wire

// ===== rtl/prot_range_decode.sv
`default_nettype none
module prot_range_decode import flash_front_pkg::*; (
	input wire logic sector_granularity_select,
	input wire logic top_bottom_select,
	input wire logic [2:0] block_protect,
	input wire logic complement_protect,
	output var prot_range_type prot
);
	logic code_none;
	logic code_all;
	logic [2:0] shift_amt;
	logic [23:0] size;
	logic [23:0] base_lo;
	logic [23:0] base_hi;
	logic [23:0] inv_lo;
	logic [23:0] inv_hi;

	// Extreme codes
	assign code_none = block_protect == 3'h0;
	assign code_all = block_protect == 3'h7;

	// Granule size; 4KB steps stop at 32KB
	assign shift_amt = (sector_granularity_select && block_protect[2]) ? 3'h3 :
		block_protect - 3'h1;
	assign size = (sector_granularity_select ? SIZE_4K : SIZE_64K) << shift_amt;

	// Plain region from top or bottom end
	assign base_lo = top_bottom_select ? '0 : (MEM_TOP - size) + ADDR_ONE;
	assign base_hi = top_bottom_select ? size - ADDR_ONE : MEM_TOP;

	// Complement of the plain region, still contiguous
	assign inv_lo = top_bottom_select ? size : '0;
	assign inv_hi = top_bottom_select ? MEM_TOP : MEM_TOP - size;

	logic any_w;
	logic [23:0] lo_w;
	logic [23:0] hi_w;

	// Final range selection, one driver for the whole struct
	assign any_w = complement_protect ? !code_all : !code_none;
	assign lo_w = (code_all || code_none) ? '0 :
		(complement_protect ? inv_lo : base_lo);
	assign hi_w = (code_all || code_none) ? MEM_TOP :
		(complement_protect ? inv_hi : base_hi);
	assign prot = '{any: any_w, lo: lo_w, hi: hi_w};

endmodule // prot_range_decode
`default_nettype wire

// ===== tb/serial_flash_cmd_protect_tb.sv
`default_nettype none
module serial_flash_cmd_protect_tb import flash_front_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
		$display("[ERR] %0t got %0h expected %0h", $time, a, b); end end

	localparam logic [7:0] MK = 8'h5A; // Arbitrary value
	localparam logic [7:0] DV = 8'h3C; // Arbitrary value
	localparam logic [15:0] WD = 16'hC3A5; // Arbitrary value

	typedef struct packed {
		logic [5:0] cfg; // Grain, top/bottom, block protect 2..0, complement
		logic q;
		logic [7:0] op;
		logic [23:0] adr;
		logic st;
	} row_type;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n;
	logic spi_clk;
	logic [3:0] io_i;
	logic [3:0] io_o;
	logic [3:0] io_oe;
	logic quad = 1'b0;
	logic [5:0] cfg = 6'h00;
	logic [6:0] stat = 7'h2B;
	logic op_done = 1'b0;
	logic busy;
	logic op_start;
	op_req_type op_req;
	logic ignored;
	logic [31:0] rx;
	int n_fail = 0;
	int check_count = 0;
	int n_start = 0;
	int n_ign = 0;
	int d_st;
	int d_ig;
	int nb;
	row_type rw;
	logic [7:0] ids [4] = '{8'hAB, 8'h90, 8'h92, 8'h94};

	// Ordinary cases: configuration, target, accepted or refused
	row_type rows [17] = '{
		'{6'h01, 1'b0, 8'h20, 24'h00_0000, 1'b0},
		'{6'h0F, 1'b0, 8'hD8, 24'h3F_0000, 1'b1},
		'{6'h03, 1'b0, 8'hD8, 24'h3F_0000, 1'b1},
		'{6'h03, 1'b0, 8'hD8, 24'h3E_0000, 1'b0},
		'{6'h1D, 1'b0, 8'h52, 24'h1F_8000, 1'b1},
		'{6'h1D, 1'b0, 8'h02, 24'h20_0010, 1'b0},
		'{6'h23, 1'b0, 8'h20, 24'h3F_F000, 1'b1},
		'{6'h23, 1'b0, 8'h52, 24'h3F_8000, 1'b0},
		'{6'h33, 1'b0, 8'h20, 24'h00_0000, 1'b1},
		'{6'h35, 1'b0, 8'h20, 24'h00_2000, 1'b0},
		'{6'h3B, 1'b1, 8'h32, 24'h00_7F00, 1'b1},
		'{6'h39, 1'b1, 8'h32, 24'h00_8000, 1'b0},
		'{6'h27, 1'b0, 8'h20, 24'h3F_C000, 1'b1},
		'{6'h27, 1'b0, 8'h20, 24'h3F_B000, 1'b0},
		'{6'h02, 1'b0, 8'h02, 24'h3E_FFF0, 1'b1},
		'{6'h02, 1'b0, 8'hC7, 24'h00_0000, 1'b0},
		'{6'h00, 1'b0, 8'h60, 24'h00_0000, 1'b1}
	};

	flash_cmd_front #(.MAKER_CODE(MK), .DEVICE_CODE_BYTE(DV), .DEVICE_CODE_WORD(WD)) DUT (
		.CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SPI_CLK(spi_clk), .IO_I(io_i),
		.IO_O(io_o), .IO_OE(io_oe), .QUAD_INSTRUCTION_MODE(quad),
		.SECTOR_GRANULARITY_SELECT(cfg[5]), .TOP_BOTTOM_SELECT(cfg[4]),
		.BLOCK_PROTECT_MSB(cfg[3]), .BLOCK_PROTECT_MID(cfg[2]), .BLOCK_PROTECT_LSB(cfg[1]),
		.COMPLEMENT_PROTECT(cfg[0]), .STATUS_BITS(stat), .OP_DONE(op_done), .BUSY(busy),
		.OP_START(op_start), .OP_REQ(op_req), .IGNORED(ignored));

	spi_host_model host (.CS_N(cs_n), .SPI_CLK(spi_clk), .IO_I(io_i), .IO_O(io_o),
		.IO_OE(io_oe), .QUAD_INSTRUCTION_MODE(quad));

	// System clock
	always #2.5 clk = ~clk;

	// Count accept and discard pulses
	always @(posedge clk)
	begin
		n_start += (op_start === 1'b1);
		n_ign += (ignored === 1'b1);
	end

	// Verdict and end of run
	task automatic results;
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One frame, then wait for its pulse when one is due
	task automatic send(input logic [63:0] tx, input int nbits, input int nrd, input bit exp);
		int s0;
		int i0;
		s0 = n_start;
		i0 = n_ign;
		host.frame(tx, nbits, nrd, rx);
		for (int k = 0; k < 40; k++)
		begin
			if (exp && (n_start != s0 || n_ign != i0))
				break;
			@(posedge clk);
		end
		@(posedge clk) #1;
		d_st = n_start - s0;
		d_ig = n_ign - i0;
		if (exp && d_st + d_ig == 0)
		begin
			n_fail++;
			$display("[ERR] %0t no completion pulse", $time);
			results();
		end
	endtask

	// Array engine finishes the running operation
	task automatic finish_op;
		`CHK(busy, 1'b1)
		op_done = 1'b1;
		@(posedge clk) #1 op_done = 1'b0;
		`CHK(busy, 1'b0)
	endtask

	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		`CHK({busy, op_start, ignored, io_oe, op_req}, 39'h0)
		foreach (rows[r])
		begin
			rw = rows[r];
			cfg = rw.cfg;
			quad = rw.q;
			nb = (rw.op == 8'hC7 || rw.op == 8'h60) ? 8 : (rw.op[3:0] == 4'h2) ? 40 : 32;
			send({rw.op, rw.adr, 8'hA5, 24'h00_0000}, nb, 0, 1'b1);
			`CHK(2 * d_st + d_ig, rw.st ? 2 : 1)
			if (rw.st)
			begin
				`CHK(op_req.code, rw.op)
				if (nb > 8)
					`CHK(op_req.addr, rw.adr)
				finish_op();
			end
		end
		// Frame cut three bits into a byte, then a clean one
		quad = 1'b0;
		cfg = 6'h00;
		send({8'h20, 56'h0}, 35, 0, 1'b1);
		`CHK(2 * d_st + d_ig, 1)
		send({8'h20, 24'h00_1000, 32'h0}, 32, 0, 1'b1);
		`CHK(2 * d_st + d_ig, 2)
		finish_op();
		// Busy: writes refused, status read still answered
		send({8'h02, 24'h00_0100, 8'h5A, 24'h0}, 40, 0, 1'b1);
		`CHK(2 * d_st + d_ig, 2)
		send({8'hD8, 56'h0}, 32, 0, 1'b1);
		`CHK(2 * d_st + d_ig, 1)
		send({8'h05, 56'h0}, 8, 8, 1'b0);
		`CHK(rx[7:0], {stat, 1'b1})
		`CHK(op_req.code, 8'h02)
		finish_op();
		send({8'h05, 56'h0}, 8, 8, 1'b0);
		`CHK(rx[7:0], {stat, 1'b0})
		// Identity read stopped after five bits
		send({8'h9F, 56'h0}, 8, 5, 1'b0);
		`CHK(2 * d_st + d_ig, 0)
		`CHK(rx[4:0], MK[7:3])
		foreach (ids[k])
		begin
			send({ids[k], 56'h0}, 32, 16, 1'b0);
			`CHK(rx[15:0], {ids[k] == 8'hAB ? DV : MK, DV})
		end
		// Word form on one line, then on four
		for (int m = 0; m < 2; m++)
		begin
			quad = m[0];
			send({8'h9F, 56'h0}, 8, 24, 1'b0);
			`CHK(rx[23:0], {MK, WD})
		end
		// Reset in mid-operation clears busy and all outputs
		quad = 1'b0;
		send({8'h60, 56'h0}, 8, 0, 1'b1);
		`CHK(busy, 1'b1)
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		`CHK({busy, op_start, ignored, io_oe, op_req}, 39'h0)
		results();
	end

endmodule // serial_flash_cmd_protect_tb
`default_nettype wire

// ===== tb/spi_host_model.sv
`default_nettype none
module spi_host_model (
	output logic CS_N,
	output logic SPI_CLK,
	output logic [3:0] IO_I,
	input wire logic [3:0] IO_O,
	input wire logic [3:0] IO_OE,
	input wire logic QUAD_INSTRUCTION_MODE
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] host_o;
	int w;

	// Pin level: device where it drives, host elsewhere
	assign IO_I = (IO_OE & IO_O) | (~IO_OE & host_o);

	// Idle: deselected, clock parked low
	initial
	begin
		CS_N = 1'b1;
		SPI_CLK = 1'b0;
		host_o = 4'h0;
	end

	// One frame: bits out MSB first, then bits sampled back
	task automatic frame(input logic [63:0] tx, input int nsend, input int nrd,
		output logic [31:0] rx);
		w = QUAD_INSTRUCTION_MODE ? 4 : 1;
		rx = '0;
		CS_N = 1'b0;
		#62.5;
		for (int i = 0; i < nsend + nrd; i += w)
		begin
			// Released lines toggle so a stale level never reads as data
			if (i < nsend)
				host_o = QUAD_INSTRUCTION_MODE ? tx[63 - i -: 4] : {3'h0, tx[63 - i]};
			else
				host_o = ~host_o;
			#62.5 SPI_CLK = 1'b1;
			if (i >= nsend)
				rx = QUAD_INSTRUCTION_MODE ? {rx[27:0], IO_I} : {rx[30:0], IO_I[1]};
			#62.5 SPI_CLK = 1'b0;
		end
		#62.5 CS_N = 1'b1;
		host_o = ~host_o;
		#100;
	endtask

endmodule // spi_host_model
`default_nettype wire
